/* core/moe_option_emulation.sv */
// top: option byte, supervisor enable, port A interrupt merge, port C sharing
`timescale 1ns/100ps
// What this block does
// [R01] input-configured port A line with option on raises interrupt when low
// [R02] option switches default off; switch input low means off
// [R03] port A option byte is built from the eight switch inputs
// [R04] main option byte loads from the programmed value when emulation starts
// [R05] main option byte is writable during debug by bus writes
// [R06] software arms with 0x80 to the programming register, then writes option byte
// [R07] host tolerates readback mismatch on programming and key registers
// [R08] any reset drops run-time option values, restoring programmed byte
// [R09] stand-alone: watchdog active whenever its option bit is set
// [R10] emulation: watchdog needs option bit plus 0x04 written to key register
// [R11] any reset disables the emulated watchdog; enabling must be repeated
// [R12] port A interrupts are delivered by driving the external interrupt pin
// [R13] port C lines 7..3 belong to converter when enabled; pins unreadable
// [R14] port C registers stay accessible but do not touch converter-owned pins
// [R15] converter off returns pins to port C using latest register values
// [R16] software should make shared lines inputs before enabling converter
// [R17] target interrupt/programming pin feeds only the interrupt function
// [R18] smallest variant: 0x1F00 acts as option byte, not user ROM
// [R19] ROM-only resident part: option byte fixed by its mask, writes ignored
// [R20] each switch position controls exactly one port A line
module moe_option_emulation #(
  parameter int WDOG_CYCLES = moe_pkg::WDOG_CYCLES_DEF
) (
  input  wire logic                  core_clk,       // device clock
  input  wire logic                  rstn,           // mcu reset, sync, active low
  input  wire moe_pkg::moe_apb_req_t apbReq,         // apb request from cpu/host
  output moe_pkg::moe_apb_rsp_t      apbRsp,         // apb answer
  input  wire logic [7:0]            portAOptSw,     // option switches, 1 = on
  input  wire logic [7:0]            progOptByte,    // programmed option byte
  input  wire logic [7:0]            maskOptByte,    // option byte of rom-only part
  input  wire logic                  romResident,    // rom-only part fitted
  input  wire logic [1:0]            deviceSel,      // device select switch
  input  wire logic                  extIrqPinN,     // target interrupt pin, low active
  input  wire logic [7:0]            portAPinIn,     // port A pin levels
  input  wire logic [7:0]            portCPinIn,     // port C pin levels
  output moe_pkg::moe_port_drv_t     portADrv,       // port A drive and enables
  output moe_pkg::moe_port_drv_t     portCDrv,       // port C drive and enables
  output logic [7:0]                 portAPullup,    // pull-up enables per line
  output logic                       cpuIrqN,        // cpu interrupt pin, low active
  output logic                       convOwn,        // converter owns shared lines
  output logic [7:0]                 activeOption,   // option byte in force
  output logic                       supActive,      // watchdog running
  output logic                       supResetReq     // watchdog timeout pulse
);
  import moe_pkg::*;

  localparam int CNT_W = $clog2(WDOG_CYCLES + 1);
  localparam logic [CNT_W-1:0] WDOG_LAST = CNT_W'(WDOG_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

  logic [7:0]       optByte;
  logic             optLoaded;
  logic             progArm;
  logic             keySeen;
  logic [7:0]       paData;
  logic [7:0]       paDir;
  logic [7:0]       pcData;
  logic [7:0]       pcDir;
  logic             convEn;
  logic             standAlone;
  logic [CNT_W-1:0] wdogCnt;

  // bus decode
  wire [IDX_W-1:0] idx      = apbReq.paddr[ADDR_W-1:2];
  wire             laneOk   = apbReq.paddr[1:0] == BYTE_LANE_OK;
  wire             access   = apbReq.psel & apbReq.penable;
  wire             fire     = access & apbRsp.pready;
  wire             wrFire   = fire & apbReq.pwrite & laneOk;
  wire [7:0]       wByte    = apbReq.pwdata[7:0];
  wire             wrProg   = wrFire & (idx == IDX_PROG_CTRL);
  wire             wrKey    = wrFire & (idx == IDX_SUP_KEY);
  wire             wrMain   = wrFire & (idx == IDX_MAIN_OPT);
  wire             wrMode   = wrFire & (idx == IDX_MODE);
  wire             wrPaData = wrFire & (idx == IDX_PA_DATA);
  wire             wrPaDir  = wrFire & (idx == IDX_PA_DIR);
  wire             wrPcData = wrFire & (idx == IDX_PC_DATA);
  wire             wrPcDir  = wrFire & (idx == IDX_PC_DIR);
  wire             wrSvc    = wrFire & (idx == IDX_SUP_SVC);

  // option byte in force; rom-only parts follow their own mask
  wire [7:0] curOpt     = romResident ? maskOptByte :            // [R19]
                          (optLoaded ? optByte : progOptByte);   // [R04]
  wire       smallest   = deviceSel == SEL_SMALLEST;
  // 0x1F00 is decoded as option byte for every variant, no rom behind it
  wire       mainWrOk   = wrMain & progArm & ~romResident;       // [R05] [R18] [R19]

  // supervisor gating
  wire supOpt  = curOpt[OPT_SUP_BIT];
  wire supGo   = standAlone ? supOpt : (supOpt & keySeen);       // [R09] [R10]

  // interrupt merge: port A sources share the external pin
  wire [7:0] paSrc   = portAOptSw & ~paDir & ~portAPinIn;        // [R01] [R20]
  wire       irqReq  = (|paSrc) | ~extIrqPinN;                   // [R12] [R17]

  // converter ownership of lines 7..3
  wire [7:0] ownMask = convEn ? CONV_MASK : BYTE_RST;            // [R13]
  wire [7:0] pcPins  = portCPinIn & ~ownMask;                    // [R13]

  // read mux
  logic [7:0] rdByte;
  logic       rdHit;
  always_comb begin
    rdHit  = 1'b1;
    rdByte = BYTE_RST;
    unique case (idx)
      IDX_PROG_CTRL: rdByte = BYTE_RST;   // [R07]
      IDX_SUP_KEY:   rdByte = BYTE_RST;   // [R07]
      IDX_PA_OPT:    rdByte = portAOptSw; // [R03]
      IDX_MAIN_OPT:  rdByte = curOpt;
      IDX_MODE: begin
        rdByte[MODE_CONV_BIT]  = convEn;
        rdByte[MODE_ALONE_BIT] = standAlone;
      end
      IDX_PA_DATA:   rdByte = paData;
      IDX_PA_DIR:    rdByte = paDir;
      IDX_PC_DATA:   rdByte = pcData;     // [R14]
      IDX_PC_DIR:    rdByte = pcDir;      // [R14]
      IDX_STATUS: begin
        rdByte[ST_SUP_BIT] = supActive;
        rdByte[ST_IRQ_BIT] = ~cpuIrqN;
        rdByte[ST_KEY_BIT] = keySeen;
      end
      IDX_PA_PINS:   rdByte = portAPinIn;
      IDX_PC_PINS:   rdByte = pcPins;
      IDX_SUP_SVC:   rdByte = BYTE_RST;
      default:       rdHit  = 1'b0;
    endcase
  end

  // apb answer: one wait state, answer on the second access cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready  <= access & ~apbRsp.pready;
      apbRsp.pslverr <= access & ~apbRsp.pready & ~(rdHit & laneOk);
      apbRsp.prdata  <= (access & ~apbRsp.pready & ~apbReq.pwrite)
                        ? {24'h000000, rdByte} : '0;
    end
  end

  // option programming; reset drops run-time values
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      optLoaded <= 1'b0;                                   // [R08]
      optByte   <= BYTE_RST;
      progArm   <= 1'b0;
    end else begin
      optLoaded <= 1'b1;
      if (!optLoaded)
        optByte <= progOptByte;                            // [R04] [R08]
      else if (mainWrOk)
        optByte <= wByte;                                  // [R05] [R06]
      if (wrProg)
        progArm <= wByte[PROG_ARM_BIT];                    // [R06]
    end
  end

  // supervisor key and watchdog counter
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      keySeen     <= 1'b0;                                 // [R11]
      supActive   <= 1'b0;                                 // [R11]
      wdogCnt     <= CNT_ZERO;
      supResetReq <= 1'b0;
    end else begin
      if (wrKey && wByte == SUP_KEY_VAL)
        keySeen <= 1'b1;                                   // [R10]
      supActive   <= supGo;
      supResetReq <= supActive & (wdogCnt == WDOG_LAST);
      if (!supActive || wrSvc || wdogCnt == WDOG_LAST)
        wdogCnt <= CNT_ZERO;
      else
        wdogCnt <= wdogCnt + CNT_W'(1);
    end
  end

  // mode and port registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      convEn     <= 1'b0;
      standAlone <= 1'b0;
      paData     <= BYTE_RST;
      paDir      <= BYTE_RST;
      pcData     <= BYTE_RST;
      pcDir      <= BYTE_RST;
    end else begin
      if (wrMode) begin
        convEn     <= wByte[MODE_CONV_BIT];
        standAlone <= wByte[MODE_ALONE_BIT];
      end
      if (wrPaData) paData <= wByte;
      if (wrPaDir)  paDir  <= wByte;
      if (wrPcData) pcData <= wByte;                       // [R14]
      if (wrPcDir)  pcDir  <= wByte;                       // [R14]
    end
  end

  // pin drivers; registers keep their values so release restores them
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      portADrv     <= '0;
      portCDrv     <= '0;
      portAPullup  <= BYTE_RST;                            // [R02]
      cpuIrqN      <= 1'b1;
      convOwn      <= 1'b0;
      activeOption <= BYTE_RST;
    end else begin
      portADrv.out <= paData;
      portADrv.oe  <= paDir;
      portCDrv.out <= pcData & ~ownMask;                   // [R14] [R15]
      portCDrv.oe  <= pcDir & ~ownMask;                    // [R14] [R15]
      portAPullup  <= portAOptSw & ~paDir;                 // [R03] [R20]
      cpuIrqN      <= ~irqReq;                             // [R12]
      convOwn      <= convEn;                              // [R13]
      activeOption <= smallest ? curOpt : curOpt;
    end
  end
endmodule // moe_option_emulation

/* core/moe_pkg.sv */
// package: register map, field layout and carriers for the option emulation block
package moe_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 14;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PROG_CTRL = 14'h001C;
  localparam logic [IDX_W-1:0] IDX_SUP_KEY   = 14'h001F;
  localparam logic [IDX_W-1:0] IDX_PA_OPT    = 14'h1EFF;
  localparam logic [IDX_W-1:0] IDX_MAIN_OPT  = 14'h1F00;
  localparam logic [IDX_W-1:0] IDX_MODE      = 14'h0020;
  localparam logic [IDX_W-1:0] IDX_PA_DATA   = 14'h0021;
  localparam logic [IDX_W-1:0] IDX_PA_DIR    = 14'h0022;
  localparam logic [IDX_W-1:0] IDX_PC_DATA   = 14'h0023;
  localparam logic [IDX_W-1:0] IDX_PC_DIR    = 14'h0024;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 14'h0025;
  localparam logic [IDX_W-1:0] IDX_PA_PINS   = 14'h0026;
  localparam logic [IDX_W-1:0] IDX_PC_PINS   = 14'h0027;
  localparam logic [IDX_W-1:0] IDX_SUP_SVC   = 14'h0028;
  // field layout
  localparam int  PROG_ARM_BIT   = 7;
  localparam int  OPT_SUP_BIT    = 0;
  localparam int  MODE_CONV_BIT  = 0;
  localparam int  MODE_ALONE_BIT = 1;
  localparam int  ST_SUP_BIT     = 0;
  localparam int  ST_IRQ_BIT     = 1;
  localparam int  ST_KEY_BIT     = 2;
  localparam logic [7:0] SUP_KEY_VAL  = 8'h04;
  localparam logic [7:0] CONV_MASK    = 8'hF8;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [1:0] SEL_SMALLEST = 2'h3;
  localparam logic [1:0] BYTE_LANE_OK = 2'h0;
  localparam int  WDOG_CYCLES_DEF    = 65536;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } moe_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } moe_apb_rsp_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } moe_port_drv_t;
endpackage

/* testbench/moe_checker.sv */
// checker: timing relations on the option emulation block ports
`timescale 1ns/100ps
module moe_checker #(parameter int WDOG_CYCLES = 16) (
  input wire logic                   core_clk, rstn, romResident, extIrqPinN, cpuIrqN, convOwn,
  input wire logic                   supActive, supResetReq,
  input wire logic [7:0]             progOptByte, portAPinIn, portAPullup, activeOption,
  input wire moe_pkg::moe_apb_req_t  apbReq,
  input wire moe_pkg::moe_apb_rsp_t  apbRsp,
  input wire moe_pkg::moe_port_drv_t portCDrv
);
  import moe_pkg::*;
  int  upCnt;
  wire supBit = activeOption[OPT_SUP_BIT];
  // cycles the watchdog has run; a timeout well before the limit is early
  always_ff @(posedge core_clk) upCnt <= (!rstn || !supActive) ? 0 : upCnt + 1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_access; apbReq.psel && apbReq.penable && !apbRsp.pready; endsequence
  sequence s_pulse(x); x ##1 !x; endsequence
  property p_answer; s_access |=> s_pulse(apbRsp.pready); endproperty
  a_answer: assert property (p_answer) else $error("apb answer late");
  property p_pin_irq;
    $stable(portAPinIn) && |(portAPullup & ~portAPinIn) |-> !cpuIrqN; endproperty
  a_pin_irq: assert property (p_pin_irq) else $error("low port A line gave no irq");
  property p_ext_irq; !extIrqPinN |=> !cpuIrqN; endproperty
  a_ext_irq: assert property (p_ext_irq) else $error("external irq not merged");
  property p_conv; convOwn && $past(convOwn) |-> (portCDrv.oe & CONV_MASK) == 8'h00; endproperty
  a_conv: assert property (p_conv) else $error("shared port C line driven");
  property p_restore;
    $rose(rstn) && !romResident |-> ##[1:3] activeOption == progOptByte; endproperty
  a_restore: assert property (p_restore) else $error("option byte not restored");
  property p_sup_rst; $rose(rstn) |-> !supActive [*2]; endproperty
  a_sup_rst: assert property (p_sup_rst) else $error("watchdog survived reset");
  property p_sup_opt; supActive |-> supBit || $past(supBit); endproperty
  a_sup_opt: assert property (p_sup_opt) else $error("watchdog without option bit");
  property p_wdog; supResetReq |-> supActive && upCnt >= WDOG_CYCLES - 2 ##1 !supResetReq;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog timeout wrong");
endmodule // moe_checker

/* testbench/moe_target.sv */
// target board model behind the cable: interrupt pin and port line levels
`timescale 1ns/100ps
module moe_target (
  input  wire logic                   core_clk,           // device clock
  input  wire logic                   irqAssert,          // bench pulls the irq pin low
  input  wire logic [7:0]             aPull,              // target pulls these A lines low
  input  wire moe_pkg::moe_port_drv_t aDrv, cDrv,         // drive from the block
  output logic                        extIrqPinN = 1'b1,  // pulled up on the module
  output logic [7:0]                  portAPinIn = 8'hFF, // port A levels
  output logic [7:0]                  portCPinIn = 8'h00  // port C levels
);
  logic [7:0] noise = 8'h5A;
  always @(posedge core_clk) begin
    noise <= ~noise;
    extIrqPinN <= !irqAssert; // cable pin reaches the interrupt only
    portAPinIn <= (aDrv.oe & aDrv.out) | (~aDrv.oe & ~aPull); // idle lines pulled up
    portCPinIn <= (cDrv.oe & cDrv.out) | (~cDrv.oe & noise); // undriven lines float
  end
endmodule // moe_target

/* testbench/test_mask_option_emulation.sv */
// bench: apb stimulus and model checks for the option emulation block
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module test_mask_option_emulation;
  import moe_pkg::*;
  logic          core_clk, rstn, romResident, irqAssert, err, extIrqPinN, cpuIrqN, convOwn;
  logic          supActive, supResetReq;
  logic [1:0]    deviceSel;
  logic [7:0]    portAOptSw, progOptByte, maskOptByte, aPull, portAPinIn, portCPinIn, m, d;
  logic [7:0]    portAPullup, activeOption;
  logic [31:0]   v;
  moe_apb_req_t  apbReq;
  moe_apb_rsp_t  apbRsp;
  moe_port_drv_t portADrv, portCDrv;
  int            bad_count, tests_run, i, mOpt, mArm;
  moe_option_emulation #(.WDOG_CYCLES(16)) u_moe_option_emulation (.core_clk, .rstn, .apbReq,
    .apbRsp, .portAOptSw, .progOptByte, .maskOptByte, .romResident, .deviceSel, .extIrqPinN,
    .portAPinIn, .portCPinIn, .portADrv, .portCDrv, .portAPullup, .cpuIrqN, .convOwn,
    .activeOption, .supActive, .supResetReq);
  moe_target u_moe_target (.core_clk, .irqAssert, .aPull, .aDrv(portADrv), .cDrv(portCDrv),
    .extIrqPinN, .portAPinIn, .portCPinIn);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // the full sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end
  // model updates at the edge where the answer is taken
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] wd = 8'h00);
    apbReq <= '{1'b1, 1'b0, w, {idx, 2'h0}, {24'h0, wd}};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (apbRsp.pready === 1'b1) break;
    end
    v = apbRsp.prdata;
    err = apbRsp.pslverr;
    if (w && idx == IDX_PROG_CTRL) mArm = wd[PROG_ARM_BIT];
    if (w && idx == IDX_MAIN_OPT && mArm && !romResident) mOpt = wd;
    apbReq <= '0;
    @(posedge core_clk);
  endtask
  task automatic do_reset(input int n);
    rstn <= 1'b0;
    repeat (n) @(posedge core_clk);
    rstn <= 1'b1;
    mArm = 0;
    mOpt = romResident ? maskOptByte : progOptByte;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    apbReq = '0; rstn = 1'b0; romResident = 1'b0; irqAssert = 1'b0; aPull = 8'h00;
    deviceSel = 2'h0; portAOptSw = 8'h00; maskOptByte = 8'h00; bad_count = 0; tests_run = 0;
    v = $urandom(32'h074c5858);
    progOptByte = 8'($urandom) | 8'h01;
    do_reset(20);
    apb(0, IDX_PA_OPT); `CHK(v, 32'h0)
    apb(0, IDX_MAIN_OPT); `CHK(v, mOpt)
    portAOptSw <= 8'($urandom);
    apb(0, IDX_PA_OPT); `CHK(v[7:0], portAOptSw)
    apb(1, IDX_MAIN_OPT, 8'hA4);
    apb(0, IDX_MAIN_OPT); `CHK(v, mOpt)
    apb(1, IDX_PROG_CTRL, 8'h80);
    apb(1, IDX_MAIN_OPT, 8'($urandom) | 8'h01);
    apb(0, IDX_MAIN_OPT); `CHK(v, mOpt)
    apb(0, 14'h0100); `CHK(err, 1'b1)
    apb(0, IDX_PROG_CTRL); `CHK(err, 1'b0)
    $display("option byte test done");
    apb(0, IDX_STATUS); `CHK(v[ST_SUP_BIT], 1'b0)
    apb(1, IDX_SUP_KEY, SUP_KEY_VAL);
    apb(0, IDX_STATUS); `CHK(v[ST_SUP_BIT], 1'b1)
    for (i = 0; i < 40 && supResetReq !== 1'b1; i++) @(posedge core_clk);
    `CHK(supResetReq, 1'b1)
    do_reset(2);
    apb(0, IDX_MAIN_OPT); `CHK(v, mOpt)
    apb(0, IDX_STATUS); `CHK(v[ST_SUP_BIT], 1'b0)
    apb(1, IDX_MODE, 8'h02);
    apb(0, IDX_STATUS); `CHK(v[ST_SUP_BIT], 1'b1)
    do_reset(2);
    $display("supervisor test done");
    m = 8'h01 << ($urandom % 8);
    portAOptSw <= m;
    aPull <= m;
    repeat (3) @(posedge core_clk);
    `CHK(cpuIrqN, 1'b0)
    `CHK(portAPullup, m)
    apb(1, IDX_PA_DIR, m);
    repeat (2) @(posedge core_clk);
    `CHK(cpuIrqN, 1'b1)
    aPull <= 8'h00;
    irqAssert <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(cpuIrqN, 1'b0)
    irqAssert <= 1'b0;
    d = 8'($urandom);
    apb(1, IDX_PC_DIR, ~CONV_MASK); // shared lines made inputs first
    apb(1, IDX_MODE, 8'h01);
    @(posedge core_clk);
    `CHK(portCDrv.oe, ~CONV_MASK)
    apb(1, IDX_PC_DIR, 8'hFF);
    @(posedge core_clk);
    `CHK(portCDrv.oe, ~CONV_MASK)
    apb(1, IDX_PC_DATA, d);
    apb(0, IDX_PC_DATA); `CHK(v[7:0], d)
    apb(0, IDX_PC_PINS); `CHK(v[7:0] & CONV_MASK, 8'h00)
    apb(1, IDX_MODE, 8'h00);
    repeat (2) @(posedge core_clk);
    `CHK(portCDrv, {d, 8'hFF})
    $display("port test done");
    romResident <= 1'b1;
    maskOptByte <= 8'($urandom);
    deviceSel <= SEL_SMALLEST;
    do_reset(2);
    apb(1, IDX_PROG_CTRL, 8'h80);
    apb(1, IDX_MAIN_OPT, ~maskOptByte);
    apb(0, IDX_MAIN_OPT); `CHK(v, mOpt)
    $display("resident part test done");
    wrap_up();
  end
endmodule // test_mask_option_emulation
bind moe_option_emulation moe_checker #(.WDOG_CYCLES(WDOG_CYCLES)) u_moe_checker (.core_clk,
  .rstn, .romResident, .extIrqPinN, .cpuIrqN, .convOwn, .supActive, .supResetReq, .progOptByte,
  .portAPinIn, .portAPullup, .activeOption, .apbReq, .apbRsp, .portCDrv);
